// *** logic/xcvr_test_pkg.sv ***
/*
 * Shared constants, types and helper functions of the transceiver
 * channel test and latency-control logic.
 * Assumes one parallel clock and 10-bit parallel words on the line side.
 */
package xcvr_test_pkg;

    // ------------------------------------------------------------------
    // Widths and counts
    // ------------------------------------------------------------------
    localparam int        WORD_W     = 10;
    localparam int        SLIP_W     = 5;
    localparam int        SELF_W     = 16;
    localparam int        SLIP_POS   = 10;
    localparam int        BUF_DEPTH  = 2;
    localparam logic [4:0] SLIP_MAX  = 5'h09;
    localparam logic [4:0] SLIP_ZERO = 5'h00;
    localparam logic [7:0] PAT_FIRST = 8'h00;
    localparam logic [7:0] PAT_LAST  = 8'hff;
    localparam logic [9:0] HF_WORD   = 10'h2aa;
    localparam logic [9:0] LF_WORD   = 10'h3e0;
    localparam logic [9:0] IDLE_WORD = 10'h000;

    // ------------------------------------------------------------------
    // Modes
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {fm_basic, fm_pipe, fm_xaui, fm_sdi, fm_detlat} func_mode_t;
    typedef enum logic [2:0] {lb_none, lb_rev_par, lb_serial, lb_rev_ser_pre,
                              lb_rev_ser_post} loop_t;
    typedef enum logic [1:0] {st_off, st_incr, st_high, st_low} selftest_t;

    // Window of ten bits out of the current and previous word, n bits late
    function automatic logic [9:0] slip_window(input logic [9:0] cur,
                                               input logic [9:0] prev,
                                               input logic [4:0] n);
        logic [19:0] c;
        c = {cur, prev} >> (5'h0a - n);
        return c[9:0];
    endfunction

    // Whether a loopback path exists in the given functional mode
    function automatic logic loop_legal(input loop_t l, input func_mode_t m);
        logic ok;
        ok = 1'b1;
        if (l == lb_rev_par && m != fm_pipe) ok = 1'b0;
        if (l == lb_serial && m == fm_pipe) ok = 1'b0;
        if ((l == lb_rev_ser_pre || l == lb_rev_ser_post) && m == fm_xaui) ok = 1'b0;
        return ok;
    endfunction

endpackage

// *** logic/word_stream_if.sv ***
/*
 * Valid/ready word stream between the channel core and its buffer.
 * Assumes both ends share the parallel clock.
 */
`timescale 1ns/1ps
`default_nettype none
interface word_stream_if;
    logic [9:0] data;
    logic       valid;
    logic       ready;
    modport source (output data, output valid, input ready);
    modport sink   (input data, input valid, output ready);
endinterface
`default_nettype wire

// *** logic/word_buffer2.sv ***
/*
 * Two-entry word buffer with valid and ready on both sides.
 * Assumes a synchronous active-high reset on the parallel clock.
 */
`timescale 1ns/1ps
`default_nettype none
module word_buffer2 (
    input  wire logic      clk_in,
    input  wire logic      reset_in,
    word_stream_if.sink    up,
    word_stream_if.source  dn
);
    import xcvr_test_pkg::*;

    typedef struct packed {
        logic [9:0] e0;
        logic [9:0] e1;
        logic [1:0] cnt;
        logic       in_ready;
    } buf_state_t;

    buf_state_t s_q;
    buf_state_t s_d;
    logic       push;
    logic       pop;

    // ------------------------------------------------------------------
    // Handshake
    // ------------------------------------------------------------------
    // Ready is a flop so a full buffer never accepts a third word
    assign up.ready = s_q.in_ready;
    assign dn.valid = (s_q.cnt != 2'h0);
    assign dn.data  = s_q.e0;
    assign push     = up.valid & s_q.in_ready;
    assign pop      = dn.valid & dn.ready;

    // Shift on pop, then write behind the oldest word
    always_comb begin
        logic [1:0] idx;
        idx = 2'h0;
        s_d = s_q;
        if (pop) begin
            s_d.e0 = s_q.e1;
        end
        idx = s_q.cnt - {1'b0, pop};
        if (push) begin
            if (idx == 2'h0) begin
                s_d.e0 = up.data;
            end else begin
                s_d.e1 = up.data;
            end
        end
        s_d.cnt      = s_q.cnt + {1'b0, push} - {1'b0, pop};
        s_d.in_ready = (s_d.cnt != 2'(BUF_DEPTH));
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

endmodule
`default_nettype wire

// *** logic/xcvr_loopback_selftest_slip.sv ***
/*
 * Channel test and latency control: transmit bit slip, receive word
 * aligner slip report, loopback path selection and the incremental
 * self-test generator and verifier.
 * Assumes all inputs are synchronous to clk_in and that the line side
 * exchanges one 10-bit word per cycle when tx_line_ready_in is high.
 */
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Transmit delayed by slip count, zero to nine
// - Report receive bits slipped as 5-bit value
// - SDI mode is plain serdes only
// - Each held slip pulse rise shifts one bit
// - Reverse parallel loop only in PIPE mode
// - Serial loop feeds transmit into receiver
// - Serial loop still drives serial output
// - Reverse serial not in XAUI; transmit buffer only
// - Reverse serial has pre- and post-CDR variants
// - Pattern generators only in Basic mode
// - High and low frequency patterns, no verifier
// - Sixteen-bit incremental pattern looped inside PCS
// - Incremental pattern hidden from receive fabric
// - Error flag sticky until receive reset
// - Done flag on full cycle or error
// - PCS resets clear generator and verifier
module xcvr_loopback_selftest_slip (
    input  wire logic                      clk_in,
    input  wire logic                      reset_in,
    input  wire xcvr_test_pkg::func_mode_t mode_in,
    input  wire xcvr_test_pkg::loop_t      loop_sel_in,
    input  wire xcvr_test_pkg::selftest_t  selftest_in,
    input  wire logic                      tx_pcs_reset_in,
    input  wire logic                      rx_pcs_reset_in,
    input  wire logic [9:0]                tx_data_in,
    input  wire logic                      tx_valid_in,
    output logic                           tx_ready_out,
    input  wire logic                      tx_line_ready_in,
    input  wire logic [4:0]                tx_slip_in,
    output logic [9:0]                     tx_line_out,
    input  wire logic [9:0]                rx_line_in,
    input  wire logic                      bitslip_mode_in,
    input  wire logic                      rx_slip_in,
    input  wire logic [9:0]                align_pattern_in,
    output logic                           rx_sync_out,
    output logic [4:0]                     rx_slip_out,
    output logic [9:0]                     rx_data_out,
    output logic                           rx_valid_out,
    input  wire logic                      selftest_inject_in,
    output logic                           selftest_done_out,
    output logic                           selftest_err_out,
    output xcvr_test_pkg::loop_t           loop_active_out,
    output logic                           rx_buf_off_out,
    output logic                           tx_pcs_off_out
);
    import xcvr_test_pkg::*;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        func_mode_t  mode;
        loop_t       loop;
        selftest_t   st;
        logic [4:0]  tx_slip;
        logic [9:0]  tx_cur;
        logic [9:0]  tx_prev;
        logic [9:0]  tx_line;
        logic [9:0]  rx_cur;
        logic [9:0]  rx_prev;
        logic [9:0]  rx_retime;
        logic [9:0]  rx_data;
        logic        rx_valid;
        logic [4:0]  rx_slip;
        logic        rx_sync;
        logic        sp1;
        logic        sp2;
        logic [7:0]  gen;
        logic [15:0] lb_word;
        logic        lb_vld;
        logic        v_lock;
        logic [7:0]  v_exp;
        logic [7:0]  v_cnt;
        logic        done;
        logic        err;
        logic        rx_buf_off;
        logic        tx_pcs_off;
    } core_state_t;

    core_state_t   s_q;
    core_state_t   s_d;
    logic [9:0]    hit;
    logic [9:0]    aligned;
    logic          slip_fire;
    logic          fab_sel;

    word_stream_if up_if ();
    word_stream_if dn_if ();

    // ------------------------------------------------------------------
    // Fabric transmit buffer
    // ------------------------------------------------------------------
    // Buffer absorbs fabric words while a loopback or pattern owns the
    // serializer, so a stall there loses nothing
    assign up_if.data  = tx_data_in;
    assign up_if.valid = tx_valid_in;
    assign fab_sel     = (s_q.loop == lb_none || s_q.loop == lb_serial) && s_q.st == st_off;
    assign dn_if.ready = tx_line_ready_in & fab_sel;

    word_buffer2 u_txbuf (
        .clk_in   (clk_in),
        .reset_in (reset_in),
        .up       (up_if.sink),
        .dn       (dn_if.source)
    );

    // ------------------------------------------------------------------
    // Word aligner helpers
    // ------------------------------------------------------------------
    // One comparator per candidate boundary for pattern alignment
    genvar k;
    generate
        for (k = 0; k < SLIP_POS; k++) begin : g_hit
            assign hit[k] = (slip_window(s_q.rx_cur, s_q.rx_prev, 5'(k)) == align_pattern_in);
        end
    endgenerate

    assign aligned   = slip_window(s_q.rx_cur, s_q.rx_prev, s_q.rx_slip);
    // Rise counts only after the pulse has been high for two cycles
    assign slip_fire = rx_slip_in & s_q.sp1 & ~s_q.sp2;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        logic [4:0] first;
        logic [9:0] tx_next;
        logic [9:0] ser_in;
        first   = SLIP_ZERO;
        tx_next = IDLE_WORD;
        ser_in  = IDLE_WORD;
        s_d     = s_q;

        // Configuration capture; one enum value means one path at most
        s_d.mode = mode_in;
        s_d.st   = (mode_in == fm_basic) ? selftest_in : st_off;
        s_d.loop = loop_legal(loop_sel_in, mode_in) ? loop_sel_in : lb_none;
        s_d.tx_slip = (tx_slip_in > SLIP_MAX) ? SLIP_MAX : tx_slip_in;
        s_d.rx_buf_off = (s_d.loop == lb_serial);
        s_d.tx_pcs_off = (s_d.loop == lb_rev_ser_pre || s_d.loop == lb_rev_ser_post);

        // Receive input: serial loop taps the transmitter's own word
        ser_in = (s_q.loop == lb_serial) ? s_q.tx_line : rx_line_in;
        s_d.rx_prev   = s_q.rx_cur;
        s_d.rx_cur    = ser_in;
        s_d.rx_retime = rx_line_in;

        // Slip pulse history
        s_d.sp1 = rx_slip_in;
        s_d.sp2 = s_q.sp1;

        // Lowest matching boundary wins when several match
        for (int i = SLIP_POS - 1; i >= 0; i--) begin
            if (hit[i]) begin
                first = 5'(i);
            end
        end

        // SDI leaves the aligner idle: plain serdes only
        if (s_q.mode != fm_sdi) begin
            if (bitslip_mode_in) begin
                if (slip_fire) begin
                    s_d.rx_slip = (s_q.rx_slip == SLIP_MAX) ? SLIP_ZERO : s_q.rx_slip + 5'h01;
                end
            end else if (!s_q.rx_sync && (|hit)) begin
                s_d.rx_slip = first;
                s_d.rx_sync = 1'b1;
            end
        end

        // Fabric sees received data in every loopback path except while the incremental self-test runs
        s_d.rx_data  = aligned;
        s_d.rx_valid = (s_d.st != st_incr);

        // Serializer source
        case (s_q.st)
            st_high: tx_next = HF_WORD;
            st_low:  tx_next = LF_WORD;
            st_incr: tx_next = {2'b00, s_q.gen};
            default: tx_next = dn_if.valid ? dn_if.data : IDLE_WORD;
        endcase
        if (s_q.loop == lb_rev_par) begin
            tx_next = aligned;
        end
        if (tx_line_ready_in) begin
            s_d.tx_prev = s_q.tx_cur;
            s_d.tx_cur  = tx_next;
        end

        // Line output: reverse serial bypasses the transmit PCS
        case (s_q.loop)
            lb_rev_ser_pre:  s_d.tx_line = rx_line_in;
            lb_rev_ser_post: s_d.tx_line = s_q.rx_retime;
            default:         s_d.tx_line = slip_window(s_q.tx_cur, s_q.tx_prev, s_q.tx_slip);
        endcase

        // Incremental generator, looped back in parallel inside the PCS
        s_d.lb_vld = (s_q.st == st_incr);
        if (s_q.st == st_incr) begin
            s_d.gen     = s_q.gen + 8'h01;
            s_d.lb_word = {s_q.gen, s_q.gen} ^ {15'h0000, selftest_inject_in};
        end

        // Verifier: first word locks, each later word must be one more
        if (s_q.lb_vld && !s_q.done) begin
            if (!s_q.v_lock) begin
                s_d.v_lock = 1'b1;
                s_d.v_exp  = s_q.lb_word[7:0] + 8'h01;
                s_d.v_cnt  = PAT_FIRST;
            end else if (s_q.lb_word != {s_q.v_exp, s_q.v_exp}) begin
                s_d.err  = 1'b1;
                s_d.done = 1'b1;
            end else begin
                s_d.v_exp = s_q.v_exp + 8'h01;
                s_d.v_cnt = s_q.v_cnt + 8'h01;
                if (s_q.v_cnt == PAT_LAST - 8'h01) begin
                    s_d.done = 1'b1;
                end
            end
        end

        // PCS resets clear their own halves
        if (tx_pcs_reset_in) begin
            s_d.gen     = PAT_FIRST;
            s_d.lb_vld  = 1'b0;
            s_d.tx_cur  = IDLE_WORD;
            s_d.tx_prev = IDLE_WORD;
        end
        if (rx_pcs_reset_in) begin
            s_d.v_lock  = 1'b0;
            s_d.v_exp   = PAT_FIRST;
            s_d.v_cnt   = PAT_FIRST;
            s_d.done    = 1'b0;
            s_d.err     = 1'b0;
            s_d.rx_slip = SLIP_ZERO;
            s_d.rx_sync = 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs are plain state fields
    assign tx_ready_out      = up_if.ready;
    assign tx_line_out       = s_q.tx_line;
    assign rx_sync_out       = s_q.rx_sync;
    assign rx_slip_out       = s_q.rx_slip;
    assign rx_data_out       = s_q.rx_data;
    assign rx_valid_out      = s_q.rx_valid;
    assign selftest_done_out = s_q.done;
    assign selftest_err_out  = s_q.err;
    assign loop_active_out   = s_q.loop;
    assign rx_buf_off_out    = s_q.rx_buf_off;
    assign tx_pcs_off_out    = s_q.tx_pcs_off;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (reset_in);

    a_tx_slip_clamp: assert property (
        (tx_slip_in > SLIP_MAX) |=> (s_q.tx_slip == SLIP_MAX))
        else $error("transmit slip not clamped to nine");

    a_slip_step: assert property (
        (bitslip_mode_in && s_q.mode != fm_sdi && rx_slip_in && $past(rx_slip_in)
         && !$past(rx_slip_in, 2) && !rx_pcs_reset_in)
        |=> (rx_slip_out == (($past(rx_slip_out) == SLIP_MAX) ? SLIP_ZERO
                             : $past(rx_slip_out) + 5'h01)))
        else $error("bit slip did not advance by one");

    a_sdi_no_slip: assert property (
        (s_q.mode == fm_sdi && !rx_pcs_reset_in) |=> $stable(rx_slip_out))
        else $error("aligner moved in SDI mode");

    a_loop_legal: assert property (
        (s_q.loop == lb_rev_par) |-> ($past(mode_in) == fm_pipe))
        else $error("reverse parallel loop outside PIPE");

    a_serial_buf_off: assert property (
        (loop_active_out == lb_serial) |-> (rx_buf_off_out && !tx_pcs_off_out))
        else $error("receiver buffer active in serial loop");

    a_serial_tap: assert property (
        (s_q.loop == lb_serial) |=> (s_q.rx_cur == $past(tx_line_out)))
        else $error("serial loop did not feed receiver");

    a_pre_cdr_path: assert property (
        (s_d.loop == lb_rev_ser_pre && s_q.loop == lb_rev_ser_pre)
        |=> (tx_line_out == $past(rx_line_in)))
        else $error("pre-CDR loop lost raw data");

    a_selftest_basic: assert property (
        (s_q.st != st_off) |-> (s_q.mode == fm_basic))
        else $error("pattern generator outside Basic mode");

    a_incr_hidden: assert property (
        (s_q.st == st_incr) |-> !rx_valid_out)
        else $error("incremental pattern reached fabric");

    a_err_sticky: assert property (
        (selftest_err_out && !rx_pcs_reset_in) |=> selftest_err_out)
        else $error("error flag dropped without reset");

    a_done_with_err: assert property (
        selftest_err_out |-> selftest_done_out)
        else $error("error seen but done low");

    a_rx_reset_clears: assert property (
        rx_pcs_reset_in |=> (!selftest_err_out && !selftest_done_out && !s_q.v_lock))
        else $error("receive reset left verifier flags");

    a_tx_reset_clears: assert property (
        tx_pcs_reset_in |=> (s_q.gen == PAT_FIRST && !s_q.lb_vld))
        else $error("transmit reset left generator running");

endmodule
`default_nettype wire

// *** tb/fabric_src.sv ***
/*
 * Fabric-side word source for the transmit stream.
 * Assumes the bench pushes words into q off the clock edge.
 */
`timescale 1ns/1ps
`default_nettype none
module fabric_src (
    input  wire logic       clk_in,
    input  wire logic       ready_in,
    output logic [9:0]      data_out,
    output logic            valid_out
);
    // ------------------------------------------------------------------
    // Queue-driven source
    // ------------------------------------------------------------------
    logic [9:0] q[$];
    initial begin
        valid_out = 1'b0;
        data_out  = 10'h000;
    end
    // Hold each word until ready is seen at an edge; idle data toggles
    // so stale bits never pass for a fresh word
    always @(posedge clk_in) begin
        if (valid_out && ready_in) begin
            void'(q.pop_front());
        end
        valid_out <= (q.size() != 0);
        data_out  <= (q.size() != 0) ? q[0] : ~data_out;
    end
endmodule
`default_nettype wire

// *** tb/xcvr_loopback_selftest_slip_test.sv ***
/*
 * Self-checking bench of the channel test and latency-control block.
 * Assumes the fabric source model and a 125 MHz parallel clock.
 */
`timescale 1ns/1ps
`default_nettype none
module xcvr_loopback_selftest_slip_test;
    import xcvr_test_pkg::*;
    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    logic       clk_in, reset_in, tx_pcs_reset_in, rx_pcs_reset_in, tx_valid_in;
    logic       tx_ready_out, tx_line_ready_in, bitslip_mode_in, rx_slip_in;
    logic       rx_sync_out, rx_valid_out, selftest_inject_in, selftest_done_out;
    logic       selftest_err_out, rx_buf_off_out, tx_pcs_off_out;
    logic [9:0] tx_data_in, tx_line_out, rx_line_in, align_pattern_in, rx_data_out;
    logic [4:0] tx_slip_in, rx_slip_out;
    func_mode_t mode_in;
    loop_t      loop_sel_in, loop_active_out;
    selftest_t  selftest_in;
    int         err_total, comparisons;

    // Clock, 8 ns period
    initial begin
        clk_in = 1'b0;
        forever #4 clk_in = ~clk_in;
    end

    fabric_src u_src (.clk_in, .ready_in(tx_ready_out), .data_out(tx_data_in),
                      .valid_out(tx_valid_in));
    xcvr_loopback_selftest_slip u_dut (.clk_in, .reset_in, .mode_in, .loop_sel_in,
        .selftest_in, .tx_pcs_reset_in, .rx_pcs_reset_in, .tx_data_in, .tx_valid_in,
        .tx_ready_out, .tx_line_ready_in, .tx_slip_in, .tx_line_out, .rx_line_in,
        .bitslip_mode_in, .rx_slip_in, .align_pattern_in, .rx_sync_out, .rx_slip_out,
        .rx_data_out, .rx_valid_out, .selftest_inject_in, .selftest_done_out,
        .selftest_err_out, .loop_active_out, .rx_buf_off_out, .tx_pcs_off_out);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic chk(input logic [9:0] got, input logic [9:0] exp, input string m);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask

    // Expected serial word for a slip of n bits
    function automatic logic [9:0] win(input logic [9:0] c, input logic [9:0] p, input int n);
        logic [19:0] t;
        t = {c, p} >> (10 - n);
        return t[9:0];
    endfunction

    task automatic results();
        $display("comparisons %0d err_total %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Bounded wait on a self-test flag; running out ends the run
    task automatic wait_flag(input bit e, input int lim);
        for (int i = 0; i < lim; i++) begin
            cyc(1);
            if ((e ? selftest_err_out : selftest_done_out) === 1'b1) return;
        end
        err_total++;
        $display("MISMATCH %0t flag wait ran out", $time);
        results();
    endtask

    task automatic pulse(input int len);
        @(posedge clk_in);
        rx_slip_in <= 1'b1;
        repeat (len) @(posedge clk_in);
        rx_slip_in <= 1'b0;
        cyc(3);
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    // Every mode against every loop choice; illegal ones fall back to none
    task automatic t_loops();
        loop_t e;
        for (int m = 0; m < 5; m++) begin
            for (int l = 0; l < 5; l++) begin
                @(posedge clk_in);
                mode_in <= func_mode_t'(m);
                loop_sel_in <= loop_t'(l);
                e = loop_t'(l);
                if (e == lb_rev_par && func_mode_t'(m) != fm_pipe) e = lb_none;
                if (e == lb_serial && func_mode_t'(m) == fm_pipe) e = lb_none;
                if (e >= lb_rev_ser_pre && func_mode_t'(m) == fm_xaui) e = lb_none;
                cyc(2);
                chk(loop_active_out, e, "loop path");
                chk(rx_buf_off_out, e == lb_serial, "rx buffer off");
                chk(tx_pcs_off_out, e >= lb_rev_ser_pre, "tx buffer only");
            end
        end
        @(posedge clk_in);
        mode_in <= fm_basic;
        loop_sel_in <= lb_none;
    endtask

    // Three words with slip s, optionally stalled until the buffer refuses
    task automatic send(input int s, input bit stall);
        logic [9:0] w[3];
        logic [9:0] o[20];
        int n, hit, ok;
        w = '{10'h3a5, 10'h1c6, 10'h0b9};
        n = (s > 9) ? 9 : s;
        hit = 0;
        @(posedge clk_in);
        tx_slip_in <= s[4:0];
        tx_line_ready_in <= !stall;
        cyc(1);
        foreach (w[i]) u_src.q.push_back(w[i]);
        if (stall) begin
            cyc(6);
            chk(tx_ready_out, 0, "buffer full");
            @(posedge clk_in);
            tx_line_ready_in <= 1'b1;
        end
        for (int i = 0; i < 20; i++) begin
            cyc(1);
            o[i] = tx_line_out;
        end
        for (int k = 0; k < 16; k++) begin
            ok = 1;
            for (int j = 0; j < 4; j++) begin
                if (o[k + j] !== win((j < 3) ? w[j] : 10'h000, (j > 0) ? w[j - 1] : 10'h000, n))
                    ok = 0;
            end
            if (ok == 1) hit = 1;
        end
        chk(10'(hit), 10'h001, "slipped transmit stream");
    endtask

    task automatic t_slip();
        @(posedge clk_in);
        bitslip_mode_in <= 1'b1;
        pulse(1);
        chk(rx_slip_out, 0, "short slip pulse");
        for (int k = 1; k <= 11; k++) begin
            pulse(2);
            chk(rx_slip_out, 10'(k % 10), "slip step");
        end
        @(posedge clk_in);
        mode_in <= fm_sdi;
        pulse(2);
        chk(rx_slip_out, 1, "aligner frozen in sdi");
        @(posedge clk_in);
        mode_in <= fm_basic;
        rx_pcs_reset_in <= 1'b1;
        @(posedge clk_in);
        rx_pcs_reset_in <= 1'b0;
        cyc(1);
        chk(rx_slip_out, 0, "slip cleared");
    endtask

    // Pattern rotated three bits: lowest matching boundary is 3
    task automatic t_align();
        @(posedge clk_in);
        bitslip_mode_in <= 1'b0;
        tx_slip_in <= rx_slip_out;
        align_pattern_in <= 10'h0f3;
        rx_line_in <= 10'h19e;
        cyc(6);
        chk(rx_sync_out, 1, "aligner locked");
        chk(rx_slip_out, 3, "bits slipped");
        chk(rx_data_out, 10'h0f3, "aligned word");
        @(posedge clk_in);
        rx_pcs_reset_in <= 1'b1;
        cyc(1);
        chk(rx_sync_out, 0, "sync cleared");
        @(posedge clk_in);
        rx_pcs_reset_in <= 1'b0;
    endtask

    task automatic t_rsl(input loop_t l, input int d);
        logic [9:0] h[16];
        @(posedge clk_in);
        loop_sel_in <= l;
        for (int i = 0; i < 16; i++) begin
            h[i] = 10'h100 + 10'(i * 37);
            @(posedge clk_in);
            rx_line_in <= h[i];
            #1;
            if (i >= 6) chk(tx_line_out, h[i - d], "reverse serial word");
        end
        chk(tx_pcs_off_out, 1, "tx buffer only");
        @(posedge clk_in);
        loop_sel_in <= lb_none;
    endtask

    task automatic t_self();
        logic [9:0] a;
        @(posedge clk_in);
        selftest_in <= st_incr;
        wait_flag(1'b0, 400);
        chk(selftest_err_out, 0, "clean pattern");
        chk(rx_valid_out, 0, "pattern hidden from fabric");
        a = tx_line_out;
        cyc(1);
        chk(tx_line_out, {2'b00, a[7:0] + 8'h01}, "serial count");
        @(posedge clk_in);
        rx_pcs_reset_in <= 1'b1;
        @(posedge clk_in);
        rx_pcs_reset_in <= 1'b0;
        cyc(1);
        chk({selftest_done_out, selftest_err_out}, 0, "flags cleared");
        @(posedge clk_in);
        selftest_inject_in <= 1'b1;
        wait_flag(1'b1, 8);
        chk(selftest_done_out, 1, "done on error");
        @(posedge clk_in);
        selftest_inject_in <= 1'b0;
        cyc(6);
        chk(selftest_err_out, 1, "error sticky");
        @(posedge clk_in);
        tx_pcs_reset_in <= 1'b1;
        @(posedge clk_in);
        tx_pcs_reset_in <= 1'b0;
        cyc(1);
        chk(tx_line_out[7:0] < 8'h04, 1, "generator restarted");
        @(posedge clk_in);
        selftest_in <= st_high;
        cyc(3);
        chk(tx_line_out, HF_WORD, "high pattern");
        @(posedge clk_in);
        selftest_in <= st_low;
        cyc(3);
        chk(tx_line_out, LF_WORD, "low pattern");
        @(posedge clk_in);
        rx_pcs_reset_in <= 1'b1;
        mode_in <= fm_sdi;
        selftest_in <= st_incr;
        @(posedge clk_in);
        rx_pcs_reset_in <= 1'b0;
        cyc(300);
        chk({selftest_done_out, rx_valid_out}, 1, "no self-test outside basic");
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        err_total = 0;
        comparisons = 0;
        {reset_in, tx_pcs_reset_in, rx_pcs_reset_in, tx_line_ready_in} = 4'h8;
        {bitslip_mode_in, rx_slip_in, selftest_inject_in} = 3'h0;
        {rx_line_in, align_pattern_in, tx_slip_in} = 25'h0000000;
        mode_in = fm_basic;
        loop_sel_in = lb_none;
        selftest_in = st_off;
        cyc(2);
        chk(tx_ready_out, 0, "not ready in reset");
        @(posedge clk_in);
        reset_in <= 1'b0;
        cyc(1);
        chk(tx_ready_out, 1, "ready after reset");
        t_loops();
        send(0, 1'b0);
        send(5, 1'b0);
        send(9, 1'b1);
        send(31, 1'b0);
        t_slip();
        t_align();
        t_rsl(lb_rev_ser_pre, 1);
        t_rsl(lb_rev_ser_post, 2);
        t_self();
        results();
    end
endmodule
`default_nettype wire
